/* bbc_host.sv */
// Purpose: Host model that reaches the configuration bank over its byte register port.
// Assumes: One request at a time, launched just after a rising edge.
// Notes: Read data is taken one edge after the read request has been taken.
`timescale 1ns/1ps
module bbc_host
   import bbc_pkg::*;
(
   input wire logic ref_clk,
   output bbc_req_t req,
   input wire logic [7:0] reg_rdata
);
   initial req = '0;
   // An idle port shows inverted address and data so stale values cannot pass.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      begin
         @(posedge ref_clk);
         req <= '{wr, ~wr, a, d};
         @(posedge ref_clk);
         req <= '{1'b0, 1'b0, ~a, ~d};
         @(posedge ref_clk);
         q = reg_rdata;
      end
   endtask
   // A write and a read of one byte, in the same request when same is set, else on back-to-back edges.
   task automatic wr_rd(input logic same, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      begin
         @(posedge ref_clk);
         req <= '{1'b1, same, a, d};
         if (!same)
         begin
            @(posedge ref_clk);
            req <= '{1'b0, 1'b1, a, ~d};
         end
         @(posedge ref_clk);
         req <= '{1'b0, 1'b0, ~a, ~d};
         @(posedge ref_clk);
         q = reg_rdata;
      end
   endtask
endmodule

/* bbc_pkg.sv */
// Purpose: Constants and carrier types for the button baseline configuration bank.
// Assumes: Byte-wide register port behind the serial configuration interface.
// Notes: Offsets are the byte addresses of the device register map.
package bbc_pkg;

   localparam int NUM_CH = 4;

   localparam logic [7:0] ADDR_LP_STEP = 8'h13;
   localparam logic [7:0] ADDR_CH3_GAIN = 8'h14;
   localparam logic [7:0] ADDR_NP_STEP = 8'h15;
   localparam logic [7:0] ADDR_HOLD_GROUP = 8'h16;

   localparam logic [7:0] RST_LP_STEP = 8'h05;
   localparam logic [7:0] RST_CH3_GAIN = 8'h28;
   localparam logic [7:0] RST_NP_STEP = 8'h03;
   localparam logic [7:0] RST_HOLD_GROUP = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   localparam int STEP_MSB = 2;
   localparam int GAIN_MSB = 5;
   localparam int GROUP_LSB = 0;
   localparam int HOLD_LSB = 4;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bbc_req_t;

   typedef struct packed {
      logic [7:0]        lp_step;
      logic [7:0]        ch3_gain;
      logic [7:0]        np_step;
      logic [7:0]        hold_group;
      logic [NUM_CH-1:0] press;
      logic [7:0]        rdata;
   } bbc_state_t;

endpackage

/* bbc_regs.sv */
// Purpose: Button algorithm baseline, gain, pause and max-win configuration registers.
// Assumes: Requests arrive one per cycle from the serial interface back end.
// Notes: Read data appears one cycle after a read request.
`timescale 1ns/1ps

// Operation
// - Low-power tracking step is bits 2-0 of register 13h, reset 5.
// - Normal-power tracking step is bits 2-0 of register 15h, reset 03h.
// - Channel 3 gain is bits 5-0 of register 14h, reset 28h.
// - Pause bit 4+n set freezes channel n tracking while its press line asserted.
// - Bit n set places channel n in the max-win group.
// - All pause and max-win bits are read/write and reset to zero.
// - Press lines are driven only while press detection is enabled.
module bbc_regs
   import bbc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire bbc_req_t req,
   output logic [7:0] reg_rdata,
   input wire logic low_power_mode,
   input wire logic press_detect_enable,
   input wire logic [NUM_CH-1:0] press_raw,
   output logic [STEP_MSB:0] lowpower_track_step,
   output logic [STEP_MSB:0] normalpower_track_step,
   output logic [STEP_MSB:0] active_track_step,
   output logic [GAIN_MSB:0] ch3_sensitivity,
   output logic [NUM_CH-1:0] press_line,
   output logic [NUM_CH-1:0] track_freeze,
   output logic [NUM_CH-1:0] strongest_press_member
);

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic [STEP_MSB:0] step_field(input logic [7:0] r);
      step_field = r[STEP_MSB:0];
   endfunction

   bbc_state_t s_q;
   bbc_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (req.wr_en)
      begin
         // Whole bytes are stored so reserved bits read back, but only the fields leave the bank.
         case (req.addr)
            ADDR_LP_STEP: s_d.lp_step = req.wdata;
            ADDR_CH3_GAIN: s_d.ch3_gain = req.wdata;
            ADDR_NP_STEP: s_d.np_step = req.wdata;
            ADDR_HOLD_GROUP: s_d.hold_group = req.wdata;
            default: s_d.lp_step = s_q.lp_step;
         endcase
      end
      // Read returns the contents before a write in the same cycle.
      if (req.rd_en)
      begin
         case (req.addr)
            ADDR_LP_STEP: s_d.rdata = s_q.lp_step;
            ADDR_CH3_GAIN: s_d.rdata = s_q.ch3_gain;
            ADDR_NP_STEP: s_d.rdata = s_q.np_step;
            ADDR_HOLD_GROUP: s_d.rdata = s_q.hold_group;
            default: s_d.rdata = RDATA_UNMAPPED;
         endcase
      end
      s_d.press = press_detect_enable ? press_raw : '0;
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         s_q.lp_step <= RST_LP_STEP;
         s_q.ch3_gain <= RST_CH3_GAIN;
         s_q.np_step <= RST_NP_STEP;
         s_q.hold_group <= RST_HOLD_GROUP;
         s_q.press <= '0;
         s_q.rdata <= 8'h00;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   assign reg_rdata = s_q.rdata;
   assign lowpower_track_step = step_field(s_q.lp_step);
   assign normalpower_track_step = step_field(s_q.np_step);
   assign active_track_step = low_power_mode ? step_field(s_q.lp_step) : step_field(s_q.np_step);
   assign ch3_sensitivity = s_q.ch3_gain[GAIN_MSB:0];
   assign press_line = s_q.press;
   // The freeze follows the gated press line, so a disabled detector never stalls tracking.
   assign track_freeze = s_q.hold_group[HOLD_LSB +: NUM_CH] & s_q.press;
   assign strongest_press_member = s_q.hold_group[GROUP_LSB +: NUM_CH];

   ////////////////////////////////////////////////////////////////////////////

   // The checks watch ports wherever they can, so they keep their meaning if the byte storage is reorganised.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_lp_write;
      req.wr_en && req.addr == ADDR_LP_STEP |=> lowpower_track_step == $past(req.wdata[2:0]);
   endproperty
   a_lp_write: assert property (p_lp_write) else $error("low-power step not updated");

   property p_np_write;
      req.wr_en && req.addr == ADDR_NP_STEP |=> normalpower_track_step == $past(req.wdata[2:0]);
   endproperty
   a_np_write: assert property (p_np_write) else $error("normal-power step not updated");

   property p_gain_write;
      req.wr_en && req.addr == ADDR_CH3_GAIN |=> ch3_sensitivity == $past(req.wdata[5:0]);
   endproperty
   a_gain_write: assert property (p_gain_write) else $error("channel 3 gain not updated");

   property p_freeze;
      !$past(reset) |-> track_freeze == ($past(press_raw) & {NUM_CH{$past(press_detect_enable)}}
         & s_q.hold_group[HOLD_LSB +: NUM_CH]);
   endproperty
   a_freeze: assert property (p_freeze) else $error("freeze does not follow pause and press");

   property p_group_write;
      req.wr_en && req.addr == ADDR_HOLD_GROUP |=> strongest_press_member == $past(req.wdata[3:0]);
   endproperty
   a_group_write: assert property (p_group_write) else $error("max-win group not updated");

   property p_readback;
      req.wr_en && req.addr == ADDR_HOLD_GROUP ##1 req.rd_en && req.addr == ADDR_HOLD_GROUP && !req.wr_en
         |=> reg_rdata == $past(req.wdata, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("pause/max-win readback wrong");

   property p_press_gate;
      !press_detect_enable |=> press_line == 4'h0;
   endproperty
   a_press_gate: assert property (p_press_gate) else $error("press line driven while disabled");

   property p_mode_select;
      active_track_step == (low_power_mode ? lowpower_track_step : normalpower_track_step);
   endproperty
   a_mode_select: assert property (p_mode_select) else $error("wrong tracking step for mode");

   // Only writes with reserved bits set can show a leak, so the antecedents demand them.
   property p_reserved;
      req.wr_en && req.addr == ADDR_LP_STEP && req.wdata[7:3] != 5'h00
         |=> lowpower_track_step == $past(req.wdata[2:0]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits leaked into step");

   property p_gain_reserved;
      req.wr_en && req.addr == ADDR_CH3_GAIN && req.wdata[7:6] != 2'h0
         |=> ch3_sensitivity == $past(req.wdata[5:0]);
   endproperty
   a_gain_reserved: assert property (p_gain_reserved) else $error("reserved bits leaked into gain");

   property p_np_reserved;
      req.wr_en && req.addr == ADDR_NP_STEP && req.wdata[7:3] != 5'h00
         |=> normalpower_track_step == $past(req.wdata[2:0]);
   endproperty
   a_np_reserved: assert property (p_np_reserved) else $error("reserved bits leaked into normal step");

   property p_reset_values;
      $fell(reset) |-> lowpower_track_step == RST_LP_STEP[STEP_MSB:0]
         && normalpower_track_step == RST_NP_STEP[STEP_MSB:0]
         && ch3_sensitivity == RST_CH3_GAIN[GAIN_MSB:0]
         && strongest_press_member == RST_HOLD_GROUP[GROUP_LSB +: NUM_CH]
         && press_line == 4'h0 && reg_rdata == 8'h00;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

   // Fields move only on a write to their own byte; a decode slip elsewhere would disturb them.
   property p_lp_hold;
      !(req.wr_en && req.addr == ADDR_LP_STEP) |=> $stable(lowpower_track_step);
   endproperty
   a_lp_hold: assert property (p_lp_hold) else $error("low-power step changed without a write");

   property p_np_hold;
      !(req.wr_en && req.addr == ADDR_NP_STEP) |=> $stable(normalpower_track_step);
   endproperty
   a_np_hold: assert property (p_np_hold) else $error("normal-power step changed without a write");

   property p_gain_hold;
      !(req.wr_en && req.addr == ADDR_CH3_GAIN) |=> $stable(ch3_sensitivity);
   endproperty
   a_gain_hold: assert property (p_gain_hold) else $error("channel 3 gain changed without a write");

   property p_group_hold;
      !(req.wr_en && req.addr == ADDR_HOLD_GROUP) |=> $stable(strongest_press_member);
   endproperty
   a_group_hold: assert property (p_group_hold) else $error("max-win group changed without a write");

   property p_rdata_hold;
      !req.rd_en |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

   property p_freeze_off;
      !press_detect_enable |=> track_freeze == 4'h0;
   endproperty
   a_freeze_off: assert property (p_freeze_off) else $error("freeze raised while detection disabled");

   property p_press_follow;
      press_detect_enable |=> press_line == $past(press_raw);
   endproperty
   a_press_follow: assert property (p_press_follow) else $error("press line does not follow detector");

   property p_readback_lp;
      req.wr_en && req.addr == ADDR_LP_STEP ##1 req.rd_en && req.addr == ADDR_LP_STEP && !req.wr_en
         |=> reg_rdata == $past(req.wdata, 2);
   endproperty
   a_readback_lp: assert property (p_readback_lp) else $error("low-power step readback wrong");

   property p_readback_gain;
      req.wr_en && req.addr == ADDR_CH3_GAIN ##1 req.rd_en && req.addr == ADDR_CH3_GAIN && !req.wr_en
         |=> reg_rdata == $past(req.wdata, 2);
   endproperty
   a_readback_gain: assert property (p_readback_gain) else $error("channel 3 gain readback wrong");

   property p_readback_np;
      req.wr_en && req.addr == ADDR_NP_STEP ##1 req.rd_en && req.addr == ADDR_NP_STEP && !req.wr_en
         |=> reg_rdata == $past(req.wdata, 2);
   endproperty
   a_readback_np: assert property (p_readback_np) else $error("normal-power step readback wrong");

endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the button baseline configuration bank.
// Assumes: The host model issues every register request.
// Notes: Reserved bits read back as written but stay off the outputs.
`timescale 1ns/1ps
module testbench
   import bbc_pkg::*;
;
   logic ref_clk, reset, low_power_mode, press_detect_enable;
   logic [3:0] press_raw, press_line, track_freeze, strongest_press_member;
   logic [2:0] lowpower_track_step, normalpower_track_step, active_track_step;
   logic [5:0] ch3_sensitivity;
   logic [7:0] reg_rdata, q;
   bbc_req_t req;
   int error_cnt, n_compared;
   logic [7:0] adr [4] = '{ADDR_LP_STEP, ADDR_CH3_GAIN, ADDR_NP_STEP, ADDR_HOLD_GROUP};
   logic [7:0] rv [4] = '{8'h05, 8'h28, 8'h03, 8'h00};
   logic [7:0] wv [4] = '{8'hFA, 8'hC5, 8'hF9, 8'hA5};
   bbc_host host (.ref_clk, .req, .reg_rdata);
   bbc_regs dut (.ref_clk, .reset, .req, .reg_rdata, .low_power_mode, .press_detect_enable, .press_raw,
      .lowpower_track_step, .normalpower_track_step, .active_track_step, .ch3_sensitivity, .press_line,
      .track_freeze, .strongest_press_member);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      begin
         n_compared++;
         if (seen !== exp)
         begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task automatic end_sim();
      begin
         $display("compared %0d mismatches %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      #20000;
      error_cnt++;
      end_sim();
   end
   initial
   begin
      reset = 1'b1;
      low_power_mode = 1'b0;
      press_detect_enable = 1'b0;
      press_raw = 4'h0;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      chk("lp step reset", {5'h00, lowpower_track_step}, RST_LP_STEP);
      chk("np step reset", {5'h00, normalpower_track_step}, RST_NP_STEP);
      chk("active reset", {5'h00, active_track_step}, RST_NP_STEP);
      chk("gain reset", {2'h0, ch3_sensitivity}, RST_CH3_GAIN);
      chk("group reset", {4'h0, strongest_press_member}, RST_HOLD_GROUP);
      chk("freeze reset", {4'h0, track_freeze}, 8'h00);
      chk("press reset", {4'h0, press_line}, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         host.xfer(1'b0, adr[i], 8'h00, q);
         chk("reset value", q, rv[i]);
         host.xfer(1'b1, adr[i], wv[i], q);
         host.xfer(1'b0, adr[i], 8'h00, q);
         chk("read back", q, wv[i]);
      end
      host.xfer(1'b0, 8'h12, 8'h00, q);
      chk("unmapped read", q, 8'h00);
      chk("lp step", {5'h00, lowpower_track_step}, 8'h02);
      chk("gain", {2'h0, ch3_sensitivity}, 8'h05);
      chk("np step", {5'h00, normalpower_track_step}, 8'h01);
      chk("active np", {5'h00, active_track_step}, 8'h01);
      chk("group", {4'h0, strongest_press_member}, 8'h05);
      low_power_mode <= 1'b1;
      press_detect_enable <= 1'b1;
      press_raw <= 4'hF;
      repeat (2) @(posedge ref_clk);
      chk("active lp", {5'h00, active_track_step}, 8'h02);
      chk("press on", {4'h0, press_line}, 8'h0F);
      chk("freeze", {4'h0, track_freeze}, 8'h0A);
      press_detect_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("press off", {4'h0, press_line}, 8'h00);
      chk("no freeze", {4'h0, track_freeze}, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         host.wr_rd(1'b0, adr[i], ~wv[i], q);
         chk("back to back", q, ~wv[i]);
      end
      chk("lp step 2", {5'h00, lowpower_track_step}, 8'h05);
      chk("active lp 2", {5'h00, active_track_step}, 8'h05);
      chk("gain 2", {2'h0, ch3_sensitivity}, 8'h3A);
      chk("np step 2", {5'h00, normalpower_track_step}, 8'h06);
      chk("group 2", {4'h0, strongest_press_member}, 8'h0A);
      host.wr_rd(1'b1, ADDR_HOLD_GROUP, 8'h3C, q);
      chk("same-cycle read", q, 8'h5A);
      host.xfer(1'b0, ADDR_HOLD_GROUP, 8'h00, q);
      chk("same-cycle write", q, 8'h3C);
      press_detect_enable <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("freeze 2", {4'h0, track_freeze}, 8'h03);
      chk("group 3", {4'h0, strongest_press_member}, 8'h0C);
      end_sim();
   end
endmodule
